// >>> verilog/color_matrix_map.vh
// Register map, field positions, reset values and coefficient constants
`ifndef COLOR_MATRIX_MAP_VH
`define COLOR_MATRIX_MAP_VH

`define CM_ADDR_MODE 8'h01
`define CM_ADDR_OUTCTL 8'h02
`define CM_ADDR_LUMA_LOW 8'h03
`define CM_ADDR_CHROMA_LOW 8'h04
`define CM_ADDR_LUMA_HIGH 8'h05
`define CM_ADDR_GPB_HIGH 8'h06
`define CM_ADDR_GPR_HIGH 8'h07
`define CM_ADDR_BLUE_HIGH 8'h08
`define CM_ADDR_RED_HIGH 8'h09
`define CM_ADDR_TESTPAT 8'h31
`define CM_ADDR_SYNCCTL 8'h35
`define CM_ADDR_SDINPUT 8'h87

`define CM_MODE_MSB 6
`define CM_MODE_LSB 4
`define CM_BIT_YPRPB_OUT 5
`define CM_BIT_RGB_SYNC 4
`define CM_BIT_MANUAL 3
`define CM_BIT_TESTPAT 2
`define CM_BIT_PBPR_SYNC 2
`define CM_BIT_RGB_IN 7

`define CM_RST_MODE 3'h0
`define CM_RST_OUTCTL 3'h0
`define CM_RST_LUMA_LOW 8'h03
`define CM_RST_CHROMA_LOW 8'hf0
`define CM_RST_LUMA_HIGH 8'h4e
`define CM_RST_GPB_HIGH 8'h0e
`define CM_RST_GPR_HIGH 8'h24
`define CM_RST_BLUE_HIGH 8'h92
`define CM_RST_RED_HIGH 8'h7c

`define CM_MODE_SD 3'h0
`define CM_MODE_ED 3'h1
`define CM_MODE_HD 3'h2

`define CM_UNITY 10'h13b
`define CM_HD_GY 10'h13b
`define CM_HD_GU 10'h03b
`define CM_HD_GV 10'h093
`define CM_HD_BU 10'h248
`define CM_HD_RV 10'h1f0
`define CM_ED_GY 10'h13b
`define CM_ED_GU 10'h06c
`define CM_ED_GV 10'h0e1
`define CM_ED_BU 10'h22e
`define CM_ED_RV 10'h1ba

`define CM_FWD_YG 10'h0b9
`define CM_FWD_YB 10'h024
`define CM_FWD_YR 10'h05e
`define CM_FWD_BG 10'h068
`define CM_FWD_BB 10'h09e
`define CM_FWD_BR 10'h035
`define CM_FWD_RG 10'h084
`define CM_FWD_RB 10'h01a
`define CM_FWD_RR 10'h09e

`define CM_LUMA_OFS 10'h040
`define CM_CHROMA_OFS 10'h200
`define CM_RECIP 13'h0d01
`define CM_RECIP_SHIFT 20
`define CM_CODE_MAX 10'h3ff

`endif

// >>> verilog/color_matrix_row.v
// One output row of the colour matrix: three scaled terms, round, clamp
`timescale 1ns/100ps
`include "color_matrix_map.vh"

module color_matrix_row (
    input wire core_clk,
    input wire rst,
    input wire signed [10:0] x0,
    input wire signed [10:0] x1,
    input wire signed [10:0] x2,
    input wire [9:0] c0,
    input wire [9:0] c1,
    input wire [9:0] c2,
    input wire n0,
    input wire n1,
    input wire n2,
    input wire [9:0] out_offset,
    output reg [9:0] result
);
    wire signed [21:0] p0 = $signed({1'b0, c0}) * x0;
    wire signed [21:0] p1 = $signed({1'b0, c1}) * x1;
    wire signed [21:0] p2 = $signed({1'b0, c2}) * x2;
    wire signed [23:0] e0 = {{2{p0[21]}}, p0};
    wire signed [23:0] e1 = {{2{p1[21]}}, p1};
    wire signed [23:0] e2 = {{2{p2[21]}}, p2};
    // Magnitudes are stored, so the sign of each term is applied here
    wire signed [23:0] s0 = n0 ? -e0 : e0;
    wire signed [23:0] s1 = n1 ? -e1 : e1;
    wire signed [23:0] s2 = n2 ? -e2 : e2;
    wire signed [23:0] sum = s0 + s1 + s2;
    // Divide by 315 via a reciprocal; it errs slightly high so 315 is exact
    wire signed [37:0] scaled = sum * $signed({1'b0, `CM_RECIP});
    wire signed [37:0] rounded = scaled + 38'h0_0008_0000;
    wire signed [17:0] quot = rounded[37:`CM_RECIP_SHIFT];
    wire signed [17:0] adj = quot + $signed({8'h00, out_offset});

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            result <= 10'h000;
        end else if (adj < 18'sh0_0000) begin
            result <= 10'h000;
        end else if (adj > $signed({8'h00, `CM_CODE_MAX})) begin
            result <= `CM_CODE_MAX;
        end else begin
            result <= adj[9:0];
        end
    end
endmodule

// >>> verilog/video_color_space_matrix.v
// Colour space conversion matrix with its control registers
`timescale 1ns/100ps
`include "color_matrix_map.vh"

module video_color_space_matrix (
    input wire core_clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    input wire pix_valid,
    input wire [9:0] pix_luma_g,
    input wire [9:0] pix_cb_b,
    input wire [9:0] pix_cr_r,
    output reg out_valid,
    output wire [9:0] out_y_g,
    output wire [9:0] out_pb_b,
    output wire [9:0] out_pr_r,
    output wire [9:0] enc_y,
    output wire [9:0] enc_cb,
    output wire [9:0] enc_cr,
    output reg out_is_rgb,
    output wire sync_on_rgb_en,
    output wire sync_on_pbpr_en,
    output wire test_pattern_en
);
    reg [2:0] mode_reg;
    reg yprpb_out_reg;
    reg rgb_sync_reg;
    reg manual_reg;
    reg [7:0] luma_low_reg;
    reg [7:0] chroma_low_reg;
    reg [7:0] luma_high_reg;
    reg [7:0] gpb_high_reg;
    reg [7:0] gpr_high_reg;
    reg [7:0] blue_high_reg;
    reg [7:0] red_high_reg;
    reg testpat_reg;
    reg pbpr_sync_reg;
    reg rgb_in_reg;
    reg [7:0] rdata_next;

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode_reg <= `CM_RST_MODE;
            yprpb_out_reg <= 1'b0;
            rgb_sync_reg <= 1'b0;
            manual_reg <= 1'b0;
            luma_low_reg <= `CM_RST_LUMA_LOW;
            chroma_low_reg <= `CM_RST_CHROMA_LOW;
            luma_high_reg <= `CM_RST_LUMA_HIGH;
            gpb_high_reg <= `CM_RST_GPB_HIGH;
            gpr_high_reg <= `CM_RST_GPR_HIGH;
            blue_high_reg <= `CM_RST_BLUE_HIGH;
            red_high_reg <= `CM_RST_RED_HIGH;
            testpat_reg <= 1'b0;
            pbpr_sync_reg <= 1'b0;
            rgb_in_reg <= 1'b0;
        end else if (reg_wr) begin
            case (reg_addr)
                `CM_ADDR_MODE: begin
                    mode_reg <= reg_wdata[`CM_MODE_MSB:`CM_MODE_LSB];
                end
                `CM_ADDR_OUTCTL: begin
                    yprpb_out_reg <= reg_wdata[`CM_BIT_YPRPB_OUT];
                    rgb_sync_reg <= reg_wdata[`CM_BIT_RGB_SYNC];
                    manual_reg <= reg_wdata[`CM_BIT_MANUAL];
                end
                `CM_ADDR_LUMA_LOW: begin
                    luma_low_reg <= reg_wdata;
                end
                `CM_ADDR_CHROMA_LOW: begin
                    chroma_low_reg <= reg_wdata;
                end
                `CM_ADDR_LUMA_HIGH: begin
                    luma_high_reg <= reg_wdata;
                end
                `CM_ADDR_GPB_HIGH: begin
                    gpb_high_reg <= reg_wdata;
                end
                `CM_ADDR_GPR_HIGH: begin
                    gpr_high_reg <= reg_wdata;
                end
                `CM_ADDR_BLUE_HIGH: begin
                    blue_high_reg <= reg_wdata;
                end
                `CM_ADDR_RED_HIGH: begin
                    red_high_reg <= reg_wdata;
                end
                `CM_ADDR_TESTPAT: begin
                    testpat_reg <= reg_wdata[`CM_BIT_TESTPAT];
                end
                `CM_ADDR_SYNCCTL: begin
                    pbpr_sync_reg <= reg_wdata[`CM_BIT_PBPR_SYNC];
                end
                `CM_ADDR_SDINPUT: begin
                    rgb_in_reg <= reg_wdata[`CM_BIT_RGB_IN];
                end
                default: begin
                end
            endcase
        end
    end

    // Only the fields this block owns read back; other bits read as zero
    always @* begin
        rdata_next = 8'h00;
        case (reg_addr)
            `CM_ADDR_MODE: rdata_next[`CM_MODE_MSB:`CM_MODE_LSB] = mode_reg;
            `CM_ADDR_OUTCTL: begin
                rdata_next[`CM_BIT_YPRPB_OUT] = yprpb_out_reg;
                rdata_next[`CM_BIT_RGB_SYNC] = rgb_sync_reg;
                rdata_next[`CM_BIT_MANUAL] = manual_reg;
            end
            `CM_ADDR_LUMA_LOW: rdata_next = luma_low_reg;
            `CM_ADDR_CHROMA_LOW: rdata_next = chroma_low_reg;
            `CM_ADDR_LUMA_HIGH: rdata_next = luma_high_reg;
            `CM_ADDR_GPB_HIGH: rdata_next = gpb_high_reg;
            `CM_ADDR_GPR_HIGH: rdata_next = gpr_high_reg;
            `CM_ADDR_BLUE_HIGH: rdata_next = blue_high_reg;
            `CM_ADDR_RED_HIGH: rdata_next = red_high_reg;
            `CM_ADDR_TESTPAT: rdata_next[`CM_BIT_TESTPAT] = testpat_reg;
            `CM_ADDR_SYNCCTL: rdata_next[`CM_BIT_PBPR_SYNC] = pbpr_sync_reg;
            `CM_ADDR_SDINPUT: rdata_next[`CM_BIT_RGB_IN] = rgb_in_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_next;
            end
        end
    end

    assign sync_on_rgb_en = rgb_sync_reg;
    assign sync_on_pbpr_en = pbpr_sync_reg;
    assign test_pattern_en = testpat_reg;

    // Ten-bit coefficients from high byte and two low bits
    wire [9:0] luma_gain_coef =
        {luma_high_reg, luma_low_reg[1:0]};
    wire [9:0] green_from_pb_coef =
        {gpb_high_reg, chroma_low_reg[7:6]};
    wire [9:0] green_from_pr_coef =
        {gpr_high_reg, chroma_low_reg[5:4]};
    wire [9:0] blue_from_pb_coef =
        {blue_high_reg, chroma_low_reg[3:2]};
    wire [9:0] red_from_pr_coef =
        {red_high_reg, chroma_low_reg[1:0]};

    wire standard_definition = (mode_reg == `CM_MODE_SD);
    wire enhanced_high_definition = ~standard_definition;
    // RGB input is honoured only in standard definition
    wire rgb_in = standard_definition & rgb_in_reg;
    // Test patterns bypass the programmable matrix
    wire manual_active = enhanced_high_definition & manual_reg &
        ~testpat_reg;

    reg pix_vld_reg;
    reg [9:0] pa_reg;
    reg [9:0] pb_reg;
    reg [9:0] pc_reg;
    reg rgb_in_d_reg;

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pix_vld_reg <= 1'b0;
            pa_reg <= 10'h000;
            pb_reg <= 10'h000;
            pc_reg <= 10'h000;
            rgb_in_d_reg <= 1'b0;
            out_valid <= 1'b0;
            out_is_rgb <= 1'b0;
        end else begin
            pix_vld_reg <= pix_valid;
            out_valid <= pix_vld_reg;
            out_is_rgb <= ~yprpb_out_reg;
            rgb_in_d_reg <= rgb_in;
            if (pix_valid) begin
                pa_reg <= pix_luma_g;
                pb_reg <= pix_cb_b;
                pc_reg <= pix_cr_r;
            end
        end
    end

    // Remove black level, and chroma midpoint unless the input is RGB, before the products
    wire [9:0] ofs_b = rgb_in_d_reg ? `CM_LUMA_OFS : `CM_CHROMA_OFS;
    wire signed [10:0] xa = $signed({1'b0, pa_reg}) -
        $signed({1'b0, `CM_LUMA_OFS});
    wire signed [10:0] xb = $signed({1'b0, pb_reg}) - $signed({1'b0, ofs_b});
    wire signed [10:0] xc = $signed({1'b0, pc_reg}) - $signed({1'b0, ofs_b});

    reg [9:0] gy_sel;
    reg [9:0] gu_sel;
    reg [9:0] gv_sel;
    reg [9:0] bu_sel;
    reg [9:0] rv_sel;

    // Automatic coefficients follow the input mode unless manual is on
    always @* begin
        if (manual_active) begin
            gy_sel = luma_gain_coef;
            gu_sel = green_from_pb_coef;
            gv_sel = green_from_pr_coef;
            bu_sel = blue_from_pb_coef;
            rv_sel = red_from_pr_coef;
        end else begin
            case (mode_reg)
                `CM_MODE_HD: begin
                    gy_sel = `CM_HD_GY;
                    gu_sel = `CM_HD_GU;
                    gv_sel = `CM_HD_GV;
                    bu_sel = `CM_HD_BU;
                    rv_sel = `CM_HD_RV;
                end
                default: begin
                    gy_sel = `CM_ED_GY;
                    gu_sel = `CM_ED_GU;
                    gv_sel = `CM_ED_GV;
                    bu_sel = `CM_ED_BU;
                    rv_sel = `CM_ED_RV;
                end
            endcase
        end
    end

    // Row terms: lane a is luma or green, b is Cb or blue, c is Cr or red
    reg [9:0] c00, c01, c02, c10, c11, c12, c20, c21, c22;
    reg n01, n02, n10, n12, n20, n21;
    reg [9:0] off0, off1, off2;

    always @* begin
        c00 = 10'h000;
        c01 = 10'h000;
        c02 = 10'h000;
        c10 = 10'h000;
        c11 = 10'h000;
        c12 = 10'h000;
        c20 = 10'h000;
        c21 = 10'h000;
        c22 = 10'h000;
        n01 = 1'b0;
        n02 = 1'b0;
        n10 = 1'b0;
        n12 = 1'b0;
        n20 = 1'b0;
        n21 = 1'b0;
        off0 = `CM_LUMA_OFS;
        off1 = `CM_LUMA_OFS;
        off2 = `CM_LUMA_OFS;
        if (rgb_in_d_reg && yprpb_out_reg) begin
            c00 = `CM_FWD_YG;
            c01 = `CM_FWD_YB;
            c02 = `CM_FWD_YR;
            c10 = `CM_FWD_BG;
            c11 = `CM_FWD_BB;
            c12 = `CM_FWD_BR;
            c20 = `CM_FWD_RG;
            c21 = `CM_FWD_RB;
            c22 = `CM_FWD_RR;
            n10 = 1'b1;
            n12 = 1'b1;
            n20 = 1'b1;
            n21 = 1'b1;
            off1 = `CM_CHROMA_OFS;
            off2 = `CM_CHROMA_OFS;
        end else if (rgb_in_d_reg) begin
            c00 = `CM_UNITY;
            c11 = `CM_UNITY;
            c22 = `CM_UNITY;
        end else if (yprpb_out_reg) begin
            // Manual mode scales each component; automatic passes through
            c00 = manual_active ? gy_sel : `CM_UNITY;
            c11 = manual_active ? bu_sel : `CM_UNITY;
            c22 = manual_active ? rv_sel : `CM_UNITY;
            off1 = `CM_CHROMA_OFS;
            off2 = `CM_CHROMA_OFS;
        end else begin
            c00 = gy_sel;
            c01 = gu_sel;
            c02 = gv_sel;
            n01 = 1'b1;
            n02 = 1'b1;
            c10 = gy_sel;
            c11 = bu_sel;
            c20 = gy_sel;
            c22 = rv_sel;
        end
    end

    // Encoder feed stays YCrCb whatever the component output selection
    wire [9:0] e00 = rgb_in_d_reg ? `CM_FWD_YG : `CM_UNITY;
    wire [9:0] e01 = rgb_in_d_reg ? `CM_FWD_YB : 10'h000;
    wire [9:0] e02 = rgb_in_d_reg ? `CM_FWD_YR : 10'h000;
    wire [9:0] e10 = rgb_in_d_reg ? `CM_FWD_BG : 10'h000;
    wire [9:0] e11 = rgb_in_d_reg ? `CM_FWD_BB : `CM_UNITY;
    wire [9:0] e12 = rgb_in_d_reg ? `CM_FWD_BR : 10'h000;
    wire [9:0] e20 = rgb_in_d_reg ? `CM_FWD_RG : 10'h000;
    wire [9:0] e21 = rgb_in_d_reg ? `CM_FWD_RB : 10'h000;
    wire [9:0] e22 = rgb_in_d_reg ? `CM_FWD_RR : `CM_UNITY;

    color_matrix_row row_out0 (.core_clk(core_clk), .rst(rst),
        .x0(xa), .x1(xb), .x2(xc), .c0(c00), .c1(c01), .c2(c02),
        .n0(1'b0), .n1(n01), .n2(n02), .out_offset(off0),
        .result(out_y_g));
    color_matrix_row row_out1 (.core_clk(core_clk), .rst(rst),
        .x0(xa), .x1(xb), .x2(xc), .c0(c10), .c1(c11), .c2(c12),
        .n0(n10), .n1(1'b0), .n2(n12), .out_offset(off1),
        .result(out_pb_b));
    color_matrix_row row_out2 (.core_clk(core_clk), .rst(rst),
        .x0(xa), .x1(xb), .x2(xc), .c0(c20), .c1(c21), .c2(c22),
        .n0(n20), .n1(n21), .n2(1'b0), .out_offset(off2),
        .result(out_pr_r));
    color_matrix_row row_enc0 (.core_clk(core_clk), .rst(rst),
        .x0(xa), .x1(xb), .x2(xc), .c0(e00), .c1(e01), .c2(e02),
        .n0(1'b0), .n1(1'b0), .n2(1'b0), .out_offset(`CM_LUMA_OFS),
        .result(enc_y));
    color_matrix_row row_enc1 (.core_clk(core_clk), .rst(rst),
        .x0(xa), .x1(xb), .x2(xc), .c0(e10), .c1(e11), .c2(e12),
        .n0(rgb_in_d_reg), .n1(1'b0), .n2(rgb_in_d_reg),
        .out_offset(`CM_CHROMA_OFS), .result(enc_cb));
    color_matrix_row row_enc2 (.core_clk(core_clk), .rst(rst),
        .x0(xa), .x1(xb), .x2(xc), .c0(e20), .c1(e21), .c2(e22),
        .n0(rgb_in_d_reg), .n1(rgb_in_d_reg), .n2(1'b0),
        .out_offset(`CM_CHROMA_OFS), .result(enc_cr));
endmodule

// >>> testbench/video_color_space_matrix_checker.sv
// Concurrent checks on the colour matrix ports
`timescale 1ns/100ps
module video_color_space_matrix_checker (
    input wire core_clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire reg_rvalid,
    input wire pix_valid,
    input wire out_valid,
    input wire out_is_rgb,
    input wire sync_on_rgb_en,
    input wire sync_on_pbpr_en,
    input wire test_pattern_en
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    a_out_latency: assert property (
        pix_valid |-> ##2 out_valid)
        else $error("out_valid missing two cycles after a pixel");
    a_out_cause: assert property (
        out_valid |-> $past(pix_valid, 2))
        else $error("out_valid without a pixel two cycles before");
    a_rgb_flag_lag: assert property (
        reg_wr && reg_addr == 8'h02 |=> ##1
        out_is_rgb == !$past(reg_wdata[5], 2))
        else $error("out_is_rgb does not follow the output select bit");
    a_ctl_unowned_zero: assert property (
        reg_rd && reg_addr == 8'h02 |=>
        reg_rvalid && reg_rdata[7:6] == 2'b00 && reg_rdata[2:0] == 3'h0)
        else $error("unowned control bits read nonzero");
    a_testpat_bit: assert property (
        reg_wr && reg_addr == 8'h31 |=>
        test_pattern_en == $past(reg_wdata[2]))
        else $error("test_pattern_en does not follow its bit");
    a_pbpr_sync_bit: assert property (
        reg_wr && reg_addr == 8'h35 |=>
        sync_on_pbpr_en == $past(reg_wdata[2]))
        else $error("sync_on_pbpr_en does not follow its bit");
    a_luma_readback: assert property (
        reg_wr && reg_addr == 8'h05 ##2 reg_rd && reg_addr == 8'h05 |=>
        reg_rdata == $past(reg_wdata, 3))
        else $error("luma gain high byte reads back wrong");
    a_rvalid_cause: assert property (
        reg_rvalid == $past(reg_rd))
        else $error("reg_rvalid does not follow the read strobe");
endmodule

bind video_color_space_matrix video_color_space_matrix_checker u_checker (
    .core_clk(core_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .pix_valid(pix_valid),
    .out_valid(out_valid),
    .out_is_rgb(out_is_rgb),
    .sync_on_rgb_en(sync_on_rgb_en),
    .sync_on_pbpr_en(sync_on_pbpr_en),
    .test_pattern_en(test_pattern_en)
);

// >>> testbench/pixel_source.sv
// Behavioural external video source sending one 4:4:4 pixel at a time
`timescale 1ns/100ps
module pixel_source (
    input wire core_clk,
    output logic pix_valid,
    output logic [9:0] pix_luma_g,
    output logic [9:0] pix_cb_b,
    output logic [9:0] pix_cr_r
);
    initial begin
        pix_valid = 1'b0;
        pix_luma_g = 10'h000;
        pix_cb_b = 10'h000;
        pix_cr_r = 10'h000;
    end

    // Idle lines show the inverse word, so a stale sample cannot look right
    task automatic send(input logic [9:0] y, input logic [9:0] cb,
                        input logic [9:0] cr);
        @(posedge core_clk);
        #1;
        pix_valid = 1'b1;
        pix_luma_g = y;
        pix_cb_b = cb;
        pix_cr_r = cr;
        @(posedge core_clk);
        #1;
        pix_valid = 1'b0;
        pix_luma_g = ~y;
        pix_cb_b = ~cb;
        pix_cr_r = ~cr;
    endtask
endmodule

// >>> testbench/tb_video_color_space_matrix.sv
// Self-checking bench for the colour matrix registers and pixel path
`timescale 1ns/100ps
module tb_video_color_space_matrix;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire [7:0] reg_rdata;
    wire reg_rvalid, pix_valid, out_valid, out_is_rgb;
    wire [9:0] pix_luma_g, pix_cb_b, pix_cr_r;
    wire [9:0] out_y_g, out_pb_b, out_pr_r, enc_y, enc_cb, enc_cr;
    wire sync_on_rgb_en, sync_on_pbpr_en, test_pattern_en;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] rst_tab [0:6] = '{8'h03, 8'hf0, 8'h4e, 8'h0e, 8'h24,
                                  8'h92, 8'h7c};

    always #50 core_clk = ~core_clk;

    video_color_space_matrix DUT (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .pix_valid(pix_valid), .pix_luma_g(pix_luma_g),
        .pix_cb_b(pix_cb_b), .pix_cr_r(pix_cr_r), .out_valid(out_valid),
        .out_y_g(out_y_g), .out_pb_b(out_pb_b), .out_pr_r(out_pr_r),
        .enc_y(enc_y), .enc_cb(enc_cb), .enc_cr(enc_cr),
        .out_is_rgb(out_is_rgb), .sync_on_rgb_en(sync_on_rgb_en),
        .sync_on_pbpr_en(sync_on_pbpr_en),
        .test_pattern_en(test_pattern_en));

    pixel_source src (.core_clk(core_clk), .pix_valid(pix_valid),
        .pix_luma_g(pix_luma_g), .pix_cb_b(pix_cb_b), .pix_cr_r(pix_cr_r));

    task automatic conclude;
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [9:0] seen,
                         input logic [9:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge core_clk);
        #1;
        reg_rd = 1'b0;
        check("reg_rvalid", {9'h000, reg_rvalid}, 10'h001);
        check("reg_rdata", {2'b00, reg_rdata}, {2'b00, exp});
    endtask

    // Bounded wait: the answer is due on the second edge after the pixel
    task automatic pix(input logic [9:0] y, input logic [9:0] cb,
                       input logic [9:0] cr, input logic [9:0] eg,
                       input logic [9:0] eb, input logic [9:0] er);
        int i;
        src.send(y, cb, cr);
        for (i = 0; i < 4 && out_valid !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        check("out_valid", {9'h000, out_valid}, 10'h001);
        check("out_y_g", out_y_g, eg);
        check("out_pb_b", out_pb_b, eb);
        check("out_pr_r", out_pr_r, er);
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            conclude();
        end
    end

    initial begin
        int k;
        repeat (12) @(posedge core_clk);
        #1;
        rst = 1'b0;
        for (k = 0; k < 7; k++) begin
            rd_chk(8'h03 + k[7:0], rst_tab[k]);
        end
        rd_chk(8'h0a, 8'h00);
        wr(8'h02, 8'hff);
        rd_chk(8'h02, 8'h38);
        check("out_is_rgb", {9'h000, out_is_rgb}, 10'h000);
        check("rgb_sync", {9'h000, sync_on_rgb_en}, 10'h001);
        wr(8'h35, 8'h04);
        wr(8'h35, 8'h00);
        check("pbpr_sync", {9'h000, sync_on_pbpr_en}, 10'h000);
        wr(8'h01, 8'h20);
        wr(8'h02, 8'h00);
        pix(10'h040, 10'h200, 10'h264, 10'h011, 10'h040, 10'h0dd);
        check("enc_y", enc_y, 10'h040);
        check("enc_cb", enc_cb, 10'h200);
        check("enc_cr", enc_cr, 10'h264);
        check("out_is_rgb", {9'h000, out_is_rgb}, 10'h001);
        check("rgb_sync", {9'h000, sync_on_rgb_en}, 10'h000);
        wr(8'h01, 8'h10);
        pix(10'h040, 10'h200, 10'h264, 10'h000, 10'h040, 10'h0cc);
        wr(8'h01, 8'h20);
        wr(8'h02, 8'h08);
        wr(8'h05, 8'h9d);
        rd_chk(8'h05, 8'h9d);
        wr(8'h03, 8'h02);
        pix(10'h17b, 10'h200, 10'h200, 10'h2b6, 10'h2b6, 10'h2b6);
        pix(10'h3ff, 10'h200, 10'h200, 10'h3ff, 10'h3ff, 10'h3ff);
        wr(8'h04, 8'h0f);
        pix(10'h040, 10'h32c, 10'h264, 10'h000, 10'h26f, 10'h0de);
        pix(10'h040, 10'h232, 10'h264, 10'h009, 10'h09d, 10'h0de);
        wr(8'h02, 8'h28);
        pix(10'h17b, 10'h200, 10'h264, 10'h2b6, 10'h200, 10'h29e);
        wr(8'h02, 8'h08);
        wr(8'h31, 8'h04);
        pix(10'h17b, 10'h200, 10'h200, 10'h17b, 10'h17b, 10'h17b);
        wr(8'h31, 8'h00);
        wr(8'h01, 8'h10);
        // Manual mode in ED needs every coefficient rewritten for ED
        wr(8'h02, 8'h08);
        wr(8'h05, 8'h4e);
        wr(8'h03, 8'h03);
        wr(8'h06, 8'h1b);
        wr(8'h07, 8'h38);
        wr(8'h08, 8'h8b);
        wr(8'h09, 8'h6e);
        wr(8'h04, 8'h1a);
        pix(10'h17b, 10'h232, 10'h264, 10'h122, 10'h1d4, 10'h207);
        wr(8'h87, 8'h80);
        wr(8'h02, 8'h20);
        pix(10'h17b, 10'h200, 10'h264, 10'h17b, 10'h200, 10'h264);
        wr(8'h01, 8'h00);
        wr(8'h02, 8'h28);
        pix(10'h17b, 10'h17b, 10'h17b, 10'h17b, 10'h201, 10'h200);
        check("enc_cb", enc_cb, 10'h201);
        wr(8'h02, 8'h00);
        pix(10'h17b, 10'h0a0, 10'h300, 10'h17b, 10'h0a0, 10'h300);
        conclude();
    end
endmodule
